// ===== logic/pwmtw_pkg.sv
// shared constants for the pwm timer group and watchdog
// assumes a single clock domain and the plain strobe register port
package pwmtw_pkg;

  // register port shape
  localparam int ADDR_W   = 8;            // byte-free word address
  localparam int DATA_W   = 32;           // register word width
  localparam int NUM_TMR  = 5;            // one wide plus four narrow timers
  localparam int WIDE_W   = 24;           // wide counter width
  localparam int NARROW_W = 16;           // narrow counter width
  localparam int PRE_W    = 8;            // prescaler width
  localparam int NUM_FLG  = 5;            // event flags per timer

  // address split: upper nibble picks a block, lower nibble a register
  localparam int BLK_LSB  = 4;            // block field position
  localparam logic [3:0] WD_BLOCK = 4'h5; // watchdog block number

  // timer register offsets within a block
  localparam logic [3:0] REG_CTRL  = 4'h0; // control
  localparam logic [3:0] REG_COUNT = 4'h1; // live count
  localparam logic [3:0] REG_CMP0  = 4'h2; // first compare
  localparam logic [3:0] REG_CMP1  = 4'h3; // second compare
  localparam logic [3:0] REG_CAP0  = 4'h4; // capture data zero
  localparam logic [3:0] REG_CAP1  = 4'h5; // capture data one
  localparam logic [3:0] REG_STAT  = 4'h6; // flags, write one to clear
  localparam logic [3:0] REG_IEN   = 4'h7; // event enables
  localparam logic [3:0] REG_SWRST = 4'h8; // software counter reset

  // control field positions
  localparam int CTL_RUN       = 0;       // counter runs
  localparam int CTL_PRE_LSB   = 8;       // prescale divide minus one
  localparam int CTL_RSEL_LSB  = 16;      // counter reset source
  localparam int CTL_UMODE_LSB = 18;      // shadow update mode
  localparam int CTL_ACT0_LSB  = 20;      // pin action on first match
  localparam int CTL_ACT1_LSB  = 22;      // pin action on second match
  localparam int CTL_GPIO      = 24;      // pin released as input
  localparam int CTL_EDGE0_LSB = 26;      // capture zero edge select
  localparam int CTL_EDGE1_LSB = 28;      // capture one edge select

  // flag positions
  localparam int FLG_OVF  = 0;            // rollover
  localparam int FLG_CMP0 = 1;            // first compare match
  localparam int FLG_CMP1 = 2;            // second compare match
  localparam int FLG_CAP0 = 3;            // capture zero
  localparam int FLG_CAP1 = 4;            // capture one
  localparam int STAT_PIN = 8;            // pad level

  // watchdog registers and fields
  localparam logic [3:0] WD_REG_CTRL = 4'h0; // enable and timeout select
  localparam logic [3:0] WD_REG_KEY  = 4'h1; // service key
  localparam logic [3:0] WD_REG_STAT = 4'h2; // half flag and count
  localparam int WD_CTL_EN    = 0;        // enable, sticky until reset
  localparam int WD_SEL_LSB   = 8;        // timeout select
  localparam int WD_SEL_W     = 8;        // timeout select width
  localparam int WD_KEY_SVC   = 0;        // service bit
  localparam int WD_STAT_HALF = 0;        // half timeout reached
  localparam int WD_STAT_EN   = 1;        // enable state
  localparam int WD_CNT_LSB   = 8;        // count field in status
  localparam int WD_CNT_W     = 24;       // watchdog count width
  localparam int WD_STEP_MS   = 10;       // timeout step and minimum
  localparam int WD_MAX_MS    = 1300;     // longest timeout
  localparam logic [WD_SEL_W-1:0] WD_SEL_MAX = WD_SEL_W'(WD_MAX_MS / WD_STEP_MS - 1);

  // modes
  typedef enum logic [1:0] {ACT_NONE, ACT_SET, ACT_CLEAR, ACT_TOGGLE} pwmtw_act_t;
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} pwmtw_edge_t;
  typedef enum logic [1:0] {RST_ROLL, RST_CMP, RST_SW, RST_SPARE} pwmtw_rsel_t;
  typedef enum logic [1:0] {UPD_MATCH, UPD_RESET, UPD_DIRECT, UPD_SPARE} pwmtw_umode_t;

endpackage

// ===== logic/pwmtw_top.sv
// pwm timer group (one wide, four narrow counters) and watchdog
// assumes synchronous pins, one clock, strobe register port with
// read data one cycle after the read strobe
//
// Overview of operation
// - one 24-bit counter with 8-bit prescaler
// - wide counter has two compare registers
// - wide compare writes shadowed, applied per mode
// - capture edge: rising, falling or both
// - capture copies count into its register
// - five enabled wide events; rollover reset
// - only second wide match drives pin
// - first wide match never touches pins
// - pin level readable; pin releasable as input
// - four 16-bit counters with own prescalers
// - each narrow counter has two compares
// - narrow compare writes shadowed, applied per mode
// - narrow reset: rollover, compare, or software
// - narrow overflow and matches individually enabled
// - narrow match drives pin by action
// - watchdog on slow oscillator, 10ms..1.3s
// - watchdog expiry resets the processor
// - watchdog off at reset, sticky once enabled
// - half timeout status flag
//
// Decided for this implementation: the address map and the plain strobed port.
module pwmtw_top
  import pwmtw_pkg::*;
#(
  parameter int WD_OSC_HZ = 10000        // slow oscillator rate
) (
  // clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RSTN,
  // register port
  input  wire logic [pwmtw_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [pwmtw_pkg::DATA_W-1:0] WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [pwmtw_pkg::DATA_W-1:0] RDATA,
  // capture inputs of the wide timer
  input  wire logic                         CAPTURE_INPUT_ZERO,
  input  wire logic                         CAPTURE_INPUT_ONE,
  // pwm pins, bit 0 is the wide compare output
  output logic      [pwmtw_pkg::NUM_TMR-1:0] PWM_PIN_OUT,
  output logic      [pwmtw_pkg::NUM_TMR-1:0] PWM_PIN_OE,
  input  wire logic [pwmtw_pkg::NUM_TMR-1:0] PWM_PIN_IN,
  // event lines per timer
  output logic      [pwmtw_pkg::NUM_TMR-1:0] TIMER_IRQ,
  // watchdog
  input  wire logic                         WD_OSC,
  output logic                              WD_CPU_RESET
);
  import pwmtw_pkg::*;

  // slow oscillator edges per timeout step
  localparam int WD_TICKS = WD_OSC_HZ * WD_STEP_MS / 1000;

  // register hit decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] blk,
                               input logic [3:0] rg);
    hit = (a[ADDR_W-1:BLK_LSB] == blk) && (a[BLK_LSB-1:0] == rg);
  endfunction

  // pin action on a compare match
  function automatic logic apply_act(input logic pin, input logic [1:0] act);
    unique case (pwmtw_act_t'(act))
      ACT_SET:    apply_act = 1'b1;
      ACT_CLEAR:  apply_act = 1'b0;
      ACT_TOGGLE: apply_act = ~pin;
      ACT_NONE:   apply_act = pin;
    endcase
  endfunction

  // edge select test
  function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] sel);
    unique case (pwmtw_edge_t'(sel))
      EDGE_RISE: edge_hit = cur & ~prev;
      EDGE_FALL: edge_hit = ~cur & prev;
      EDGE_BOTH: edge_hit = cur ^ prev;
      EDGE_OFF:  edge_hit = 1'b0;
    endcase
  endfunction

  // per timer read words, selected read word and capture history
  logic [DATA_W-1:0] rd_word [NUM_TMR+1];   // read mux inputs, last is watchdog
  logic [DATA_W-1:0] next_rdata;            // selected read word
  logic [1:0]        cap_prev;              // capture pins one cycle ago

  // capture pin history
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cap_prev <= 2'h0;
    end else begin
      cap_prev <= {CAPTURE_INPUT_ONE, CAPTURE_INPUT_ZERO};
    end
  end

  // timers
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    localparam int         W    = (i == 0) ? WIDE_W : NARROW_W;
    localparam logic [3:0] BLK  = 4'(i);
    localparam logic [WIDE_W-1:0] MASK = WIDE_W'((64'h1 << W) - 64'h1);

    logic [DATA_W-1:0]  ctrl;         // control word
    logic [PRE_W-1:0]   pre_cnt;      // prescale counter
    logic [WIDE_W-1:0]  cnt;          // counter
    logic [WIDE_W-1:0]  cmp0;         // active first compare
    logic [WIDE_W-1:0]  cmp1;         // active second compare
    logic [WIDE_W-1:0]  sh0;          // shadow first compare
    logic [WIDE_W-1:0]  sh1;          // shadow second compare
    logic               pend0;        // shadow zero waiting
    logic               pend1;        // shadow one waiting
    logic [WIDE_W-1:0]  cap0;         // capture data zero
    logic [WIDE_W-1:0]  cap1;         // capture data one
    logic [NUM_FLG-1:0] flg;          // sticky event flags
    logic [NUM_FLG-1:0] ien;          // event enables
    logic               pin;          // driven pin level
    logic               run;          // counter enabled
    logic               tick;         // prescaled advance
    logic               m0;           // first compare match
    logic               m1;           // second compare match
    logic               ovf;          // wrap from all ones
    logic               cmp_rst;      // reset on second compare
    logic               sw_rst;       // software reset write
    logic               cnt_rst;      // any counter restart
    logic               cap0_ev;      // capture zero event
    logic               cap1_ev;      // capture one event
    logic [NUM_FLG-1:0] set_flg;      // flags raised this cycle
    logic [NUM_FLG-1:0] clr_flg;      // flags cleared by software
    logic [WIDE_W-1:0]  wval;         // write data cut to counter width
    logic               direct;       // compare writes bypass shadow

    assign run   = ctrl[CTL_RUN];
    assign tick  = run && (pre_cnt == ctrl[CTL_PRE_LSB +: PRE_W]);
    assign m0    = tick && (cnt == cmp0);
    assign m1    = tick && (cnt == cmp1);
    assign ovf   = tick && (cnt == MASK);
    // wide counter resets only on rollover
    assign cmp_rst = (i != 0) && m1
                     && (pwmtw_rsel_t'(ctrl[CTL_RSEL_LSB +: 2]) == RST_CMP);
    assign sw_rst  = (i != 0) && WR && hit(ADDR, BLK, REG_SWRST)
                     && (pwmtw_rsel_t'(ctrl[CTL_RSEL_LSB +: 2]) == RST_SW);
    assign cnt_rst = ovf || cmp_rst || sw_rst;
    assign wval    = WDATA[WIDE_W-1:0] & MASK;
    assign direct  = !run || (pwmtw_umode_t'(ctrl[CTL_UMODE_LSB +: 2]) == UPD_DIRECT);

    // capture only on the wide timer
    if (i == 0) begin : g_cap
      assign cap0_ev = edge_hit(CAPTURE_INPUT_ZERO, cap_prev[0],
                                ctrl[CTL_EDGE0_LSB +: 2]);
      assign cap1_ev = edge_hit(CAPTURE_INPUT_ONE, cap_prev[1],
                                ctrl[CTL_EDGE1_LSB +: 2]);
    end else begin : g_nocap
      assign cap0_ev = 1'b0;
      assign cap1_ev = 1'b0;
    end

    assign set_flg = {cap1_ev, cap0_ev, m1, m0, ovf};
    assign clr_flg = (WR && hit(ADDR, BLK, REG_STAT)) ? WDATA[NUM_FLG-1:0]
                                                      : {NUM_FLG{1'b0}};

    // control and enable registers
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        ctrl <= 32'h0;
        ien  <= 5'h0;
      end else begin
        if (WR && hit(ADDR, BLK, REG_CTRL)) begin
          ctrl <= WDATA;
        end
        if (WR && hit(ADDR, BLK, REG_IEN)) begin
          ien <= WDATA[NUM_FLG-1:0];
        end
      end
    end

    // prescaler
    always_ff @(posedge CLK) begin
      if (!RSTN || !run || tick) begin
        pre_cnt <= 8'h0;
      end else begin
        pre_cnt <= pre_cnt + 8'h1;
      end
    end

    // counter
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        cnt <= 24'h0;
      end else if (cnt_rst) begin
        cnt <= 24'h0;
      end else if (tick) begin
        cnt <= cnt + 24'h1;
      end
    end

    // first compare with shadow; a new write beats a transfer
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        cmp0  <= 24'h0;
        sh0   <= 24'h0;
        pend0 <= 1'b0;
      end else if (WR && hit(ADDR, BLK, REG_CMP0)) begin
        if (direct) begin
          cmp0  <= wval;
          pend0 <= 1'b0;
        end else begin
          sh0   <= wval;
          pend0 <= 1'b1;
        end
      end else if (pend0 && ((pwmtw_umode_t'(ctrl[CTL_UMODE_LSB +: 2]) == UPD_RESET)
                             ? cnt_rst : m0)) begin
        cmp0  <= sh0;
        pend0 <= 1'b0;
      end
    end

    // second compare with shadow
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        cmp1  <= 24'h0;
        sh1   <= 24'h0;
        pend1 <= 1'b0;
      end else if (WR && hit(ADDR, BLK, REG_CMP1)) begin
        if (direct) begin
          cmp1  <= wval;
          pend1 <= 1'b0;
        end else begin
          sh1   <= wval;
          pend1 <= 1'b1;
        end
      end else if (pend1 && ((pwmtw_umode_t'(ctrl[CTL_UMODE_LSB +: 2]) == UPD_RESET)
                             ? cnt_rst : m1)) begin
        cmp1  <= sh1;
        pend1 <= 1'b0;
      end
    end

    // capture data
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        cap0 <= 24'h0;
        cap1 <= 24'h0;
      end else begin
        if (cap0_ev) begin
          cap0 <= cnt;
        end
        if (cap1_ev) begin
          cap1 <= cnt;
        end
      end
    end

    // sticky flags, a new event wins over a clear
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        flg <= 5'h0;
      end else begin
        flg <= (flg & ~clr_flg) | set_flg;
      end
    end

    // pin drive; second match is tested first so it wins a tie
    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        pin <= 1'b0;
      end else if (i == 0) begin
        if (m1) begin
          pin <= apply_act(pin, ctrl[CTL_ACT1_LSB +: 2]);
        end
      end else if (m1) begin
        pin <= apply_act(pin, ctrl[CTL_ACT1_LSB +: 2]);
      end else if (m0) begin
        pin <= apply_act(pin, ctrl[CTL_ACT0_LSB +: 2]);
      end
    end

    // pin released as input when set up as general io
    assign PWM_PIN_OUT[i] = pin;
    assign PWM_PIN_OE[i]  = ~ctrl[CTL_GPIO];
    assign TIMER_IRQ[i]   = |(flg & ien);

    // read words of this block
    always_comb begin
      rd_word[i] = 32'h0;
      unique case (ADDR[BLK_LSB-1:0])
        REG_CTRL:  rd_word[i] = ctrl;
        REG_COUNT: rd_word[i] = 32'(cnt);
        REG_CMP0:  rd_word[i] = 32'(cmp0);
        REG_CMP1:  rd_word[i] = 32'(cmp1);
        REG_CAP0:  rd_word[i] = 32'(cap0);
        REG_CAP1:  rd_word[i] = 32'(cap1);
        REG_STAT:  rd_word[i] = 32'(flg) | (32'(PWM_PIN_IN[i]) << STAT_PIN);
        REG_IEN:   rd_word[i] = 32'(ien);
        default:   rd_word[i] = 32'h0;
      endcase
    end
  end

  // watchdog
  logic                wd_en;     // enabled, sticky
  logic [WD_SEL_W-1:0] wd_sel;    // timeout steps minus one
  logic [WD_CNT_W-1:0] wd_cnt;    // oscillator edges since service
  logic [WD_CNT_W-1:0] wd_limit;  // edges to expiry
  logic                osc_prev;  // oscillator one cycle ago
  logic                osc_edge;  // oscillator rising edge
  logic                wd_svc;    // service write
  logic                wd_half;   // half timeout reached

  assign osc_edge = WD_OSC & ~osc_prev;
  assign wd_svc   = WR && hit(ADDR, WD_BLOCK, WD_REG_KEY) && WDATA[WD_KEY_SVC];
  assign wd_limit = WD_CNT_W'((32'(wd_sel) + 32'h1) * 32'(WD_TICKS));
  assign wd_half  = wd_cnt >= (wd_limit >> 1);

  // oscillator history
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= WD_OSC;
    end
  end

  // enable and timeout select; enable cannot be cleared by writes
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wd_en  <= 1'b0;
      wd_sel <= 8'h0;
    end else if (WR && hit(ADDR, WD_BLOCK, WD_REG_CTRL)) begin
      wd_en  <= wd_en | WDATA[WD_CTL_EN];
      wd_sel <= (WDATA[WD_SEL_LSB +: WD_SEL_W] > WD_SEL_MAX) ? WD_SEL_MAX
                : WDATA[WD_SEL_LSB +: WD_SEL_W];
    end
  end

  // timeout counter
  always_ff @(posedge CLK) begin
    if (!RSTN || !wd_en || wd_svc) begin
      wd_cnt <= 24'h0;
    end else if (osc_edge && (wd_cnt < wd_limit)) begin
      wd_cnt <= wd_cnt + 24'h1;
    end
  end

  // processor reset held until device reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      WD_CPU_RESET <= 1'b0;
    end else if (wd_en && (wd_cnt >= wd_limit)) begin
      WD_CPU_RESET <= 1'b1;
    end
  end

  // watchdog read words
  always_comb begin
    rd_word[NUM_TMR] = 32'h0;
    unique case (ADDR[BLK_LSB-1:0])
      WD_REG_CTRL: rd_word[NUM_TMR] = 32'(wd_en) | (32'(wd_sel) << WD_SEL_LSB);
      WD_REG_STAT: rd_word[NUM_TMR] = (32'(wd_half) << WD_STAT_HALF)
                                      | (32'(wd_en) << WD_STAT_EN)
                                      | (32'(wd_cnt) << WD_CNT_LSB);
      default:     rd_word[NUM_TMR] = 32'h0;
    endcase
  end

  // block select for reads, unmapped reads zero
  always_comb begin
    next_rdata = 32'h0;
    for (int b = 0; b <= NUM_TMR; b++) begin
      if (ADDR[ADDR_W-1:BLK_LSB] == 4'(b)) begin
        next_rdata = rd_word[b];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? next_rdata : 32'h0;
    end
  end

endmodule // pwmtw_top

// ===== bench/pwmtw_monitor.sv
// port checker for the pwm timer group and watchdog
// assumes it is bound into pwmtw_top and given the same oscillator rate
module pwmtw_monitor
  import pwmtw_pkg::*;
#(
  parameter int WD_OSC_HZ = 10000          // slow oscillator rate
) (
  // clock and reset
  input wire logic                         CLK,
  input wire logic                         RSTN,
  // register port
  input wire logic [pwmtw_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pwmtw_pkg::DATA_W-1:0] WDATA,
  input wire logic                         WR,
  input wire logic                         RD,
  input wire logic [pwmtw_pkg::DATA_W-1:0] RDATA,
  // pins, events and watchdog
  input wire logic [pwmtw_pkg::NUM_TMR-1:0] PWM_PIN_OUT,
  input wire logic [pwmtw_pkg::NUM_TMR-1:0] PWM_PIN_OE,
  input wire logic [pwmtw_pkg::NUM_TMR-1:0] TIMER_IRQ,
  input wire logic                         WD_OSC,
  input wire logic                         WD_CPU_RESET
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MIN_EDGES = WD_OSC_HZ / 100; // shortest timeout in edges
  logic        wd_en;                         // enable seen on the bus
  logic        osc_q;                         // last oscillator sample
  logic [23:0] osc_cnt;                       // edges since service, never below design's
  logic [1:0]  w_act1;                        // wide second-match action
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // bus shadows of the enable and wide action
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wd_en  <= 1'b0;
      w_act1 <= 2'h0;
    end else begin
      if (WR && ADDR == {WD_BLOCK, WD_REG_CTRL} && WDATA[WD_CTL_EN]) wd_en <= 1'b1;
      if (WR && ADDR == 8'h00) w_act1 <= WDATA[CTL_ACT1_LSB +: 2];
    end
  end
  // oscillator edges since the last service write
  always_ff @(posedge CLK) begin
    osc_q <= WD_OSC;
    if (!RSTN || (WR && ADDR == {WD_BLOCK, WD_REG_KEY} && WDATA[WD_KEY_SVC])) osc_cnt <= '0;
    else if (WD_OSC && !osc_q) osc_cnt <= osc_cnt + 24'h1;
  end
  a_wd_reset_holds: assert property (WD_CPU_RESET |=> WD_CPU_RESET)
    else $error("processor reset dropped before reset");
  a_wd_needs_enable: assert property (WD_CPU_RESET |-> wd_en)
    else $error("processor reset while watchdog disabled");
  a_wd_min_timeout: assert property ($rose(WD_CPU_RESET) |-> osc_cnt >= MIN_EDGES)
    else $error("watchdog expired too early");
  a_wd_en_sticky: assert property (RD && ADDR == 8'h52 && wd_en |=> RDATA[WD_STAT_EN])
    else $error("watchdog enable reads clear");
  a_rdata_idle_zero: assert property (!RD |=> RDATA == '0)
    else $error("read data outside read slot");
  a_oe_from_ctrl: assert property (WR && ADDR[3:0] == REG_CTRL && ADDR[7:4] < 4'h5 |=>
    PWM_PIN_OE[$past(ADDR[7:4])] == !$past(WDATA[CTL_GPIO]))
    else $error("pin enable not set by control");
  a_irq_drop_write: assert property (|($past(TIMER_IRQ) & ~TIMER_IRQ) |-> $past(WR))
    else $error("event line dropped without write");
  a_wide_pin_quiet: assert property (w_act1 == ACT_NONE && $past(w_act1) == ACT_NONE
    |-> $stable(PWM_PIN_OUT[0]))
    else $error("wide pin moved without second action");
endmodule // pwmtw_monitor

bind pwmtw_top pwmtw_monitor #(.WD_OSC_HZ(WD_OSC_HZ)) pwmtw_monitor_i (.CLK, .RSTN, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .PWM_PIN_OUT, .PWM_PIN_OE, .TIMER_IRQ, .WD_OSC, .WD_CPU_RESET);

// ===== bench/pwmtw_pads.sv
// far-side model: capture sources and the pad wires
// assumes requests come from the bench on rising edges
module pwmtw_pads
  import pwmtw_pkg::*;
(
  input  wire logic               clk,
  // requests from the bench
  input  wire logic               cap0_req,
  input  wire logic               cap1_req,
  input  wire logic [NUM_TMR-1:0] ext_lvl,
  // design pin side
  input  wire logic [NUM_TMR-1:0] pin_out,
  input  wire logic [NUM_TMR-1:0] pin_oe,
  output logic                    cap0,
  output logic                    cap1,
  output logic [NUM_TMR-1:0]      pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // capture sources switch just after an edge
  always_ff @(posedge clk) begin
    cap0 <= cap0_req;
    cap1 <= cap1_req;
  end
  // wire level: design drive when enabled, else the outside level
  always_comb pad = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // pwmtw_pads

// ===== bench/test_pwm_timers_and_watchdog.sv
// self-checking bench for the timer group and watchdog
// assumes pwmtw_top, the pad model and the bound checker
module test_pwm_timers_and_watchdog
  import pwmtw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, osc = 0;  // bus and clocks
  logic [7:0]  addr = '0;                                   // word address
  logic [31:0] wdata = '0, rdata;                           // data
  logic        cap0_req = 0, cap1_req = 0, cap0, cap1, wd_rst;
  logic [4:0]  ext = '0, pin_out, pin_oe, pad, irq;         // pins and events
  int          num_errors = 0, num_checks = 0;              // tallies
  always #50 clk = ~clk;
  // slow oscillator: a rising edge every ten clocks
  always begin
    repeat (5) @(posedge clk);
    osc <= ~osc;
  end
  pwmtw_top #(.WD_OSC_HZ(200)) pwmtw_top_i (.CLK(clk), .RSTN(rstn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CAPTURE_INPUT_ZERO(cap0),
    .CAPTURE_INPUT_ONE(cap1), .PWM_PIN_OUT(pin_out), .PWM_PIN_OE(pin_oe), .PWM_PIN_IN(pad),
    .TIMER_IRQ(irq), .WD_OSC(osc), .WD_CPU_RESET(wd_rst));
  pwmtw_pads pwmtw_pads_i (.clk(clk), .cap0_req(cap0_req), .cap1_req(cap1_req),
    .ext_lvl(ext), .pin_out(pin_out), .pin_oe(pin_oe), .cap0(cap0), .cap1(cap1), .pad(pad));
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write, returns once the edge has landed
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    check(d & m, e);
  endtask
  // bounded wait for a pin level
  task automatic wait_pin(input int k, input logic v);
    int n;
    for (n = 0; n < 300 && pin_out[k] !== v; n++) @(negedge clk);
    if (n == 300) begin
      num_errors++;
      final_report();
    end
  endtask
  // length in cycles of the next full stretch at level v
  task automatic run_len(input int k, input logic v, output int n);
    wait_pin(k, !v);
    wait_pin(k, v);
    for (n = 0; n < 300 && pin_out[k] === v; n++) @(negedge clk);
  endtask
  task automatic cap(input logic v);
    @(posedge clk);
    cap0_req <= v;
    cap1_req <= v;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    check({wd_rst, irq, pin_out, pin_oe}, {1'b0, 5'h0, 5'h0, 5'h1f});
    wr_reg(8'h60, 32'hffffffff);
    rd_chk(8'h60, 32'hffffffff, 32'h0);
    rd_chk(8'h52, 32'h2, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_narrow;
    int n;
    wr_reg(8'h17, 32'h7);
    wr_reg(8'h12, 32'h5);
    wr_reg(8'h13, 32'h9);
    wr_reg(8'h10, 32'h910001);
    run_len(1, 1'b1, n);
    check(n, 4);
    run_len(1, 1'b0, n);
    check(n, 6);
    check(irq[1], 1'b1);
    rd_chk(8'h16, 32'h1f, 32'h6);
    wr_reg(8'h17, 32'h0);
    check(irq[1], 1'b0);
    wr_reg(8'h13, 32'h7);
    run_len(1, 1'b1, n);
    run_len(1, 1'b1, n);
    check(n, 2);
    wr_reg(8'h22, 32'h3);
    wr_reg(8'h23, 32'h9);
    wr_reg(8'h20, 32'h310101);
    run_len(2, 1'b1, n);
    check(n, 20);
    wr_reg(8'h20, 32'h390101);
    wr_reg(8'h22, 32'h5);
    rd_chk(8'h22, 32'hffff, 32'h5);
    wr_reg(8'h30, 32'h20001);
    repeat (30) @(posedge clk);
    wr_reg(8'h38, 32'h1);
    rd_reg(8'h31, n);
    check(n < 4, 1'b1);
    $display("test narrow done");
  endtask
  task automatic t_wide;
    logic [31:0] d;
    wr_reg(8'h07, 32'h18);
    wr_reg(8'h00, 32'h301);
    repeat (40) @(posedge clk);
    wr_reg(8'h00, 32'h0);
    rd_reg(8'h01, d);
    check(d > 8 && d < 13, 1'b1);
    for (int e = 0; e < 4; e++) begin
      wr_reg(8'h00, (e << 26) | (e << 28));
      cap(1'b1);
      check(irq[0], e[0]);
      rd_chk(8'h06, 32'h18, {e[0], e[0], 3'b0});
      wr_reg(8'h06, 32'h1f);
      cap(1'b0);
      rd_chk(8'h06, 32'h18, {e[1], e[1], 3'b0});
      wr_reg(8'h06, 32'h1f);
    end
    rd_chk(8'h04, 32'hffffff, d);
    rd_chk(8'h05, 32'hffffff, d);
    wr_reg(8'h02, 32'hc);
    wr_reg(8'h03, 32'he);
    wr_reg(8'h00, 32'hd00001);
    repeat (3) @(negedge clk);
    check(pin_out[0], 1'b0);
    wait_pin(0, 1'b1);
    check(pin_out[0], 1'b1);
    wr_reg(8'h40, 32'h1000000);
    check(pin_oe, 5'h0f);
    @(posedge clk) ext <= 5'h10;
    rd_chk(8'h46, 32'h100, 32'h100);
    @(posedge clk) ext <= 5'h00;
    rd_chk(8'h46, 32'h100, 32'h0);
    $display("test wide done");
  endtask
  task automatic t_watchdog;
    wr_reg(8'h50, 32'h101);
    wr_reg(8'h50, 32'h100);
    rd_chk(8'h52, 32'h2, 32'h2);
    repeat (6) begin
      repeat (20) @(posedge clk);
      wr_reg(8'h51, 32'h1);
    end
    rd_chk(8'h52, 32'h1, 32'h0);
    check(wd_rst, 1'b0);
    repeat (25) @(posedge clk);
    rd_chk(8'h52, 32'h1, 32'h1);
    check(wd_rst, 1'b0);
    repeat (30) @(negedge clk);
    check(wd_rst, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(wd_rst, 1'b0);
    rd_chk(8'h52, 32'h2, 32'h0);
    $display("test watchdog done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_narrow();
    t_wide();
    t_watchdog();
    final_report();
  end
endmodule // test_pwm_timers_and_watchdog
